//--- shared/pcg_regs.svh
// Purpose: Offsets, field positions, reset values for peripheral clock gating
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes:   Offsets for group 0 and group 1 run/sleep/deep-sleep, and mode, are chosen
`ifndef PCG_REGS_SVH
`define PCG_REGS_SVH
`define PCG_OFS_RUN0       12'h100
`define PCG_OFS_RUN1       12'h104
`define PCG_OFS_SLP0       12'h110
`define PCG_OFS_SLP1       12'h114
`define PCG_OFS_DSL0       12'h120
`define PCG_OFS_DSL1       12'h124
`define PCG_OFS_MODE       12'h130
`define PCG_RST_GRP0       32'h00000040
`define PCG_RST_GRP1       32'h00000000
`define PCG_MASK_GRP0      32'h01010348
`define PCG_MASK_GRP1      32'h030f5033
`define PCG_MASK_MODE      32'h00000001
`define PCG_BIT_NET0       24
`define PCG_BIT_CONV0      16
`define PCG_RATE_LO        8
`define PCG_RATE_HI        9
`define PCG_BIT_RETAIN     6
`define PCG_BIT_WDOG       3
`define PCG_BIT_AUTO       0
`define PCG_SYNC_STAGES    2
`endif

//--- shared/pcg_pkg.sv
// Purpose: Types for peripheral clock gating block
// Assumes: Nothing beyond SystemVerilog
// Notes:   Power mode comes from the power controller
package pcg_pkg;
  typedef enum logic [1:0] {
    PCG_MODE_RUN,
    PCG_MODE_SLEEP,
    PCG_MODE_DEEP
  } pcg_mode_t;
  typedef enum logic [1:0] {
    PCG_RATE_125K = 2'h0,
    PCG_RATE_250K = 2'h1,
    PCG_RATE_500K = 2'h2
  } pcg_rate_t;
endpackage

//--- hdl/pcg_sync.sv
// Purpose: Two-flop synchroniser for a bundle of levels
// Assumes: Inputs come from outside the sys_clk domain
// Notes:   First stage read only by second stage
`timescale 1ns/10ps
module pcg_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } pcg_sync_state_t;
  pcg_sync_state_t cur;
  pcg_sync_state_t next_cur;
  always_comb begin
    next_cur.meta = async_in;
    next_cur.held = cur.meta;
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
  assign sync_out = cur.held;
endmodule

//--- hdl/pcg_top.sv
// Purpose: Peripheral clock gating registers with APB slave and fault check
// Assumes: Power mode arrives asynchronously; peripheral accesses are
//          presented by the bus fabric as a same-clock select vector
// Notes:   Enables are registered, so a gate changes only at a clock edge
`timescale 1ns/10ps
`include "pcg_regs.svh"
module pcg_top (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  power_mode,
  input  wire logic [31:0] periph_sel0,
  input  wire logic [31:0] periph_sel1,
  input  wire logic        periph_req,
  output logic      [31:0] clk_en_grp0,
  output logic      [31:0] clk_en_grp1,
  output logic      [1:0]  converter_sample_rate,
  output logic             bus_fault
);
  typedef struct packed {
    logic [31:0] run0;
    logic [31:0] run1;
    logic [31:0] slp0;
    logic [31:0] slp1;
    logic [31:0] dsl0;
    logic [31:0] dsl1;
    logic        auto_gating_select;
    logic [31:0] en0;
    logic [31:0] en1;
    logic [1:0]  rate;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        fault;
  } pcg_state_t;

  pcg_state_t cur;
  pcg_state_t next_cur;
  logic [1:0] mode_sync;

  // Mode comes from the power controller, possibly another domain
  pcg_sync #(
    .WIDTH (2)
  ) u_mode_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .async_in (power_mode),
    .sync_out (mode_sync)
  );

  function automatic logic [31:0] read_word(input pcg_state_t s, input logic [11:0] a);
    unique case (a)
      `PCG_OFS_RUN0: read_word = s.run0;
      `PCG_OFS_RUN1: read_word = s.run1;
      `PCG_OFS_SLP0: read_word = s.slp0;
      `PCG_OFS_SLP1: read_word = s.slp1;
      `PCG_OFS_DSL0: read_word = s.dsl0;
      `PCG_OFS_DSL1: read_word = s.dsl1;
      `PCG_OFS_MODE: read_word = {31'h0, s.auto_gating_select};
      default:       read_word = 32'h0;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `PCG_OFS_RUN0) || (a == `PCG_OFS_RUN1) || (a == `PCG_OFS_SLP0) ||
                (a == `PCG_OFS_SLP1) || (a == `PCG_OFS_DSL0) || (a == `PCG_OFS_DSL1) ||
                (a == `PCG_OFS_MODE);
  endfunction

  logic        access;
  logic        wr;
  logic [31:0] w0;
  logic [31:0] w1;
  pcg_pkg::pcg_mode_t mode;

  always_comb begin
    next_cur = cur;
    access = psel && penable && !cur.ready;
    wr = access && pwrite && is_mapped(paddr);
    w0 = pwdata & `PCG_MASK_GRP0;
    w1 = pwdata & `PCG_MASK_GRP1;
    mode = pcg_pkg::pcg_mode_t'(mode_sync);
    // One wait state: ready rises one cycle into the access phase
    next_cur.ready = access;
    next_cur.slverr = access && !is_mapped(paddr);
    next_cur.rdata = (access && !pwrite) ? read_word(cur, paddr) : 32'h0;
    if (wr) begin
      unique case (paddr)
        `PCG_OFS_RUN0: next_cur.run0 = w0;
        `PCG_OFS_RUN1: next_cur.run1 = w1;
        `PCG_OFS_SLP0: next_cur.slp0 = w0;
        `PCG_OFS_SLP1: next_cur.slp1 = w1;
        `PCG_OFS_DSL0: next_cur.dsl0 = w0;
        `PCG_OFS_DSL1: next_cur.dsl1 = w1;
        default:       next_cur.auto_gating_select = pwdata[`PCG_BIT_AUTO];
      endcase
    end
    // Sleep sets only apply with auto gating; else run set stays in force
    next_cur.en0 = cur.run0;
    next_cur.en1 = cur.run1;
    if (cur.auto_gating_select) begin
      unique case (mode)
        pcg_pkg::PCG_MODE_SLEEP: begin
          next_cur.en0 = cur.slp0;
          next_cur.en1 = cur.slp1;
        end
        pcg_pkg::PCG_MODE_DEEP: begin
          next_cur.en0 = cur.dsl0;
          next_cur.en1 = cur.dsl1;
        end
        default: begin
          next_cur.en0 = cur.run0;
          next_cur.en1 = cur.run1;
        end
      endcase
    end
    next_cur.rate = next_cur.en0[`PCG_RATE_HI:`PCG_RATE_LO];
    // Any access to a peripheral whose enable is clear faults
    next_cur.fault = periph_req &&
                     (|(periph_sel0 & ~cur.en0) || |(periph_sel1 & ~cur.en1));
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '0;
      cur.run0 <= `PCG_RST_GRP0;
      cur.slp0 <= `PCG_RST_GRP0;
      cur.dsl0 <= `PCG_RST_GRP0;
      cur.run1 <= `PCG_RST_GRP1;
      cur.slp1 <= `PCG_RST_GRP1;
      cur.dsl1 <= `PCG_RST_GRP1;
    end else begin
      cur <= next_cur;
    end
  end

  assign prdata = cur.rdata;
  assign pready = cur.ready;
  assign pslverr = cur.slverr;
  assign clk_en_grp0 = cur.en0 & `PCG_MASK_GRP0 & ~32'h00000300;
  assign clk_en_grp1 = cur.en1;
  assign converter_sample_rate = cur.rate;
  assign bus_fault = cur.fault;
endmodule

//--- dv/pcg_top_asserts.sv
// Purpose: Port checks for clock gating registers
// Assumes: One clock, rst_b async active low
// Notes:   Masks are the writable-bit maps
`timescale 1ns/10ps
module pcg_top_asserts (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] periph_sel0,
  input wire logic [31:0] periph_sel1,
  input wire logic        periph_req,
  input wire logic [31:0] clk_en_grp0,
  input wire logic [31:0] clk_en_grp1,
  input wire logic        bus_fault
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire acc = psel && penable && !pready;
  // Any selected unit without its clock
  wire hole = |(periph_sel0 & ~clk_en_grp0) || |(periph_sel1 & ~clk_en_grp1);
  answer_one_a: assert property (acc |=> pready ##1 !pready) else $error("pready");
  rsv_run1_a: assert property (acc && paddr == 12'h104 |=> (prdata & ~32'h030f5033) == 0)
    else $error("run1 rsv");
  rsv_deep0_a: assert property (acc && paddr == 12'h120 |=> (prdata & ~32'h01010348) == 0)
    else $error("deep0 rsv");
  unmapped_a: assert property (acc && paddr == 12'h108 |=> pslverr && prdata == 0)
    else $error("unmapped");
  mapped_ok_a: assert property (acc && (paddr == 12'h104 || paddr == 12'h120) |=> !pslverr)
    else $error("err");
  en_rsv_a: assert property ((clk_en_grp1 & ~32'h030f5033) == 0) else $error("en1");
  fault_a: assert property (periph_req && hole |=> bus_fault) else $error("no fault");
  quiet_a: assert property (!(periph_req && hole) |=> !bus_fault) else $error("fault");
  cover property (periph_req && hole);
  cover property (acc && paddr == 12'h108);
  cover property (acc && paddr == 12'h120);
endmodule
bind pcg_top pcg_top_asserts u_chk (.*);

//--- dv/pcg_core_model.sv
// Purpose: Core making one-cycle peripheral accesses
// Assumes: Selects are meaningless while request is low
// Notes:   Idle selects inverted so stale values never pass
`timescale 1ns/10ps
module pcg_core_model (
  input  wire logic        sys_clk,
  output logic             periph_req,
  output logic      [31:0] periph_sel0,
  output logic      [31:0] periph_sel1
);
  initial begin
    periph_req = 1'b0;
    periph_sel0 = 32'h0;
    periph_sel1 = 32'h0;
  end
  task automatic access(input logic [31:0] s0, input logic [31:0] s1);
    @(posedge sys_clk);
    periph_req <= 1'b1;
    periph_sel0 <= s0;
    periph_sel1 <= s1;
    @(posedge sys_clk);
    periph_req <= 1'b0;
    periph_sel0 <= ~s0;
    periph_sel1 <= ~s1;
  endtask
endmodule

//--- dv/pcg_top_tb.sv
// Purpose: Directed bench for clock gating registers
// Assumes: Mode change settles within five cycles
// Notes:   Core model stands in for the processor
`timescale 1ns/10ps
module pcg_top_tb;
  logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, periph_req, bus_fault, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, periph_sel0, periph_sel1, clk_en_grp0, clk_en_grp1, q;
  logic [1:0]  power_mode, converter_sample_rate;
  int          mismatches, checked, cycles;
  pcg_top dut (.*);
  pcg_core_model core (.*);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (++cycles == 3000) begin
    mismatches++;
    tally_and_finish();
  end
  task automatic tally_and_finish();
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask
  // Request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_regs();
    apb(1'b0, 12'h104, 32'h0);
    cmp("run1", 32'h0, q);
    apb(1'b0, 12'h120, 32'h0);
    cmp("deep0", 32'h40, q);
    apb(1'b1, 12'h104, '1);
    apb(1'b0, 12'h104, 32'h0);
    cmp("run1", 32'h030f5033, q);
    cmp("en1", 32'h030f5033, clk_en_grp1);
    apb(1'b1, 12'h120, '1);
    apb(1'b0, 12'h120, 32'h0);
    cmp("deep0", 32'h01010348, q);
    apb(1'b0, 12'h108, 32'h0);
    cmp("slverr", 32'h1, e);
  endtask
  task automatic t_mode();
    power_mode <= 2'h2;
    repeat (5) @(posedge sys_clk);
    cmp("en1", 32'h030f5033, clk_en_grp1);
    apb(1'b1, 12'h130, 32'h1);
    repeat (2) @(posedge sys_clk);
    cmp("en1", 32'h0, clk_en_grp1);
    for (int r = 0; r < 3; r++) begin
      apb(1'b1, 12'h120, {22'h0, r[1:0], 8'h08});
      repeat (2) @(posedge sys_clk);
      cmp("rate", {30'h0, r[1:0]}, {30'h0, converter_sample_rate});
      cmp("en0", 32'h8, clk_en_grp0);
    end
    // Sleep set must win over deep and run sets
    power_mode <= 2'h1;
    repeat (5) @(posedge sys_clk);
    cmp("en0", 32'h40, clk_en_grp0);
    cmp("en1", 32'h0, clk_en_grp1);
    apb(1'b1, 12'h130, 32'h0);
    power_mode <= 2'h0;
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic t_fault();
    core.access(32'h0, 32'h4000);
    #1;
    cmp("fault", 32'h0, bus_fault);
    apb(1'b1, 12'h104, 32'h0);
    repeat (2) @(posedge sys_clk);
    core.access(32'h0, 32'h4000);
    #1;
    cmp("fault", 32'h1, bus_fault);
    core.access(32'h8, 32'h0);
    #1;
    cmp("fault", 32'h1, bus_fault);
  endtask
  initial begin
    rst_b = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, power_mode} = '0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    t_mode();
    t_fault();
    tally_and_finish();
  end
endmodule
